// File: rtl/tos_pkg.sv
package tos_pkg;
  // Arm code values carried in the activate byte
  localparam logic [7:0] TOS_ARM_IDLE = 8'h00;
  localparam logic [7:0] TOS_ARM_GO   = 8'h03;
  // Feedback byte bit positions
  localparam int TOS_FB_OUT1 = 0;
  localparam int TOS_FB_TRI1 = 1;
  localparam int TOS_FB_OUT2 = 2;
  localparam int TOS_FB_TRI2 = 3;
  // Reset values
  localparam logic [3:0]  TOS_TARGET_RST = 4'h0;
  localparam logic [63:0] TOS_TIME_RST   = 64'h0000000000000000;
  // Bus cycle length in clocks used by the master end
  localparam int TOS_BUS_CYCLE_NS  = 1000;
  localparam int TOS_CLK_NS        = 40;
  localparam int TOS_BUS_CYCLE_CLK = TOS_BUS_CYCLE_NS / TOS_CLK_NS;
  // Device scheduler states
  typedef enum logic [1:0] {TOS_IDLE, TOS_ARMED, TOS_DONE} tos_state_t;
  // Master sequencer states
  typedef enum logic [1:0] {TOS_M_IDLE, TOS_M_LOAD, TOS_M_ARM, TOS_M_WAIT} tos_mstate_t;
endpackage

// File: rtl/tos_link_if.sv
`timescale 1ns/1ns
interface tos_link_if;
  logic        cycle_stb;   // Process data exchange pulse
  logic [63:0] start_time;  // Absolute start time
  logic [3:0]  target;      // Out1,Tri1,Out2,Tri2
  logic [7:0]  arm_code;    // Activate byte
  logic [7:0]  feedback;    // Applied states
  modport device (input cycle_stb, input start_time, input target, input arm_code,
                  output feedback);
  modport master (output cycle_stb, output start_time, output target, output arm_code,
                  input feedback);
endinterface

// File: rtl/tos_time_cmp.sv
`timescale 1ns/1ns
module tos_time_cmp
  import tos_pkg::*;
(
  input  wire logic [63:0] now,       // Local time
  input  wire logic [63:0] deadline,  // Armed start time
  output logic             reached    // Now at or past deadline
);
  // Unsigned compare; wrap of 64-bit time is not a practical concern
  assign reached = (now >= deadline);
endmodule // tos_time_cmp

// File: rtl/tos_device.sv
`timescale 1ns/1ns
module tos_device
  import tos_pkg::*;
(
  input  wire logic       clk,          // 25 MHz
  input  wire logic       rst,          // Sync, high; also power loss
  input  wire logic       ce,           // Clock enable
  tos_link_if.device      link,         // Process data from master
  input  wire logic [63:0] local_time,  // Local distributed time
  output logic [1:0]      drive,        // Channel drive to power stage
  output logic [1:0]      tristate,     // Channel high-impedance
  output logic            armed,        // Event pending
  output logic            fired         // One-cycle switch pulse
);
  tos_state_t  state;           // Scheduler state
  logic [7:0]  arm_prev;        // Last arm code seen
  logic [63:0] deadline;        // Armed start time
  logic [3:0]  applied;         // Applied output image
  logic        reached;         // Time compare result
  logic        arm_edge;        // 0 to 3 transition

  // Compare in separate leaf to keep the wide adder out of the FSM
  tos_time_cmp u_cmp (
    .now      (local_time),
    .deadline (deadline),
    .reached  (reached)
  );

  // Only a fresh exchange counts; arm code is stale between strobes
  assign arm_edge = link.cycle_stb && (arm_prev == TOS_ARM_IDLE)
                    && (link.arm_code == TOS_ARM_GO);

  // Previous arm code tracked per exchange
  always_ff @(posedge clk) begin
    if (rst) begin
      arm_prev <= TOS_ARM_IDLE;
    end else if (ce && link.cycle_stb) begin
      arm_prev <= link.arm_code;
    end
  end

  // Scheduler; reset doubles as power loss and clears the pending time
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= TOS_IDLE;
      deadline <= TOS_TIME_RST;
    end else if (ce) begin
      case (state)
        TOS_IDLE: begin
          if (arm_edge) begin
            deadline <= link.start_time;
            state    <= TOS_ARMED;
          end
        end
        TOS_ARMED: begin
          if (reached) begin
            state <= TOS_DONE;
          end
        end
        TOS_DONE: begin
          // Wait for master to drop arm code before rearming
          if (link.cycle_stb && link.arm_code == TOS_ARM_IDLE) begin
            state <= TOS_IDLE;
          end
        end
        default: state <= TOS_IDLE;
      endcase
    end
  end

  // Output image; targets sampled live at the firing moment
  always_ff @(posedge clk) begin
    if (rst) begin
      applied <= TOS_TARGET_RST;
      fired   <= 1'b0;
    end else if (ce) begin
      fired <= 1'b0;
      if (state == TOS_ARMED && reached) begin
        applied <= link.target;
        fired   <= 1'b1;
      end
    end
  end

  // Registered status and power stage outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      armed    <= 1'b0;
      drive    <= 2'h0;
      tristate <= 2'h0;
    end else if (ce) begin
      armed    <= (state == TOS_ARMED);
      drive    <= {applied[TOS_FB_OUT2], applied[TOS_FB_OUT1]};
      tristate <= {applied[TOS_FB_TRI2], applied[TOS_FB_TRI1]};
    end
  end

  // Feedback byte, upper nibble reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      link.feedback <= 8'h00;
    end else if (ce) begin
      link.feedback <= {4'h0, applied};
    end
  end
endmodule // tos_device

// File: rtl/tos_master.sv
`timescale 1ns/1ns
module tos_master
  import tos_pkg::*;
(
  input  wire logic        clk,         // 25 MHz
  input  wire logic        rst,         // Sync, high
  input  wire logic        ce,          // Clock enable
  tos_link_if.master       link,        // To device
  input  wire logic        req,         // Request one switching event
  input  wire logic [63:0] req_time,    // Absolute start time
  input  wire logic [3:0]  req_target,  // Target image
  input  wire logic [63:0] master_time_copy, // Coarse copy of time
  output logic             busy,        // Sequence running
  output logic             done,        // Pulse, feedback matched
  output logic             late         // Pulse, start time was past
);
  tos_mstate_t mstate;        // Sequencer state
  logic [7:0]  cyc_cnt;       // Bus cycle divider
  logic        stb;           // Internal exchange strobe
  logic [3:0]  want;          // Image to compare
  logic        past;          // Compare on coarse time

  tos_time_cmp u_late (
    .now      (master_time_copy),
    .deadline (req_time),
    .reached  (past)
  );

  assign stb = (cyc_cnt == 8'(TOS_BUS_CYCLE_CLK - 1));

  // Bus cycle timing
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_cnt        <= 8'h00;
      link.cycle_stb <= 1'b0;
    end else if (ce) begin
      cyc_cnt        <= stb ? 8'h00 : cyc_cnt + 8'h01;
      link.cycle_stb <= stb;
    end
  end

  // Sequencer, leaves idle on req, then one step per bus cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      mstate          <= TOS_M_IDLE;
      link.arm_code   <= TOS_ARM_IDLE;
      link.start_time <= TOS_TIME_RST;
      link.target     <= TOS_TARGET_RST;
      want            <= TOS_TARGET_RST;
      busy            <= 1'b0;
      done            <= 1'b0;
      late            <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      late <= 1'b0;
      case (mstate)
        TOS_M_IDLE: begin
          if (req) begin
            link.start_time <= req_time;
            link.target     <= req_target;
            link.arm_code   <= TOS_ARM_IDLE;
            want            <= req_target;
            late            <= past;
            busy            <= 1'b1;
            mstate          <= TOS_M_LOAD;
          end
        end
        TOS_M_LOAD: begin
          if (stb) begin
            mstate <= TOS_M_ARM;
          end
        end
        TOS_M_ARM: begin
          if (stb) begin
            link.arm_code <= TOS_ARM_GO;
            mstate        <= TOS_M_WAIT;
          end
        end
        TOS_M_WAIT: begin
          // Targets and arm code held throughout
          if (stb && link.feedback[3:0] == want) begin
            link.arm_code <= TOS_ARM_IDLE;
            done          <= 1'b1;
            busy          <= 1'b0;
            mstate        <= TOS_M_IDLE;
          end
        end
        default: mstate <= TOS_M_IDLE;
      endcase
    end
  end
endmodule // tos_master

// File: tb/tos_asserts.sv
`timescale 1ns/1ns
module tos_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cycle_stb,
  input wire logic [63:0] start_time,
  input wire logic [3:0]  target,
  input wire logic [7:0]  arm_code,
  input wire logic [7:0]  feedback
);
  // One clock domain for every property
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Upper nibble of feedback unused
  property p_fb_hi; feedback[7:4] == 4'h0; endproperty
  a_fb_hi: assert property (p_fb_hi) else $error("feedback high bits set");
  // Applied image is the held target, all four bits
  property p_fb_tgt; $changed(feedback) |-> feedback[3:0] == $past(target); endproperty
  a_fb_tgt: assert property (p_fb_tgt) else $error("feedback not target");
  // Switching only happens while armed
  property p_fb_arm; $changed(feedback) |-> arm_code == 8'h03; endproperty
  a_fb_arm: assert property (p_fb_arm) else $error("switch while not armed");
  // Targets and time frozen while armed
  property p_hold;
    arm_code == 8'h03 && $past(arm_code) == 8'h03 |-> $stable(target) && $stable(start_time);
  endproperty
  a_hold: assert property (p_hold) else $error("target moved while armed");
  // Only idle and go codes are sent
  property p_arm_val; arm_code == 8'h00 || arm_code == 8'h03; endproperty
  a_arm_val: assert property (p_arm_val) else $error("bad arm code");
  // No second exchange within 8 clocks of a strobe
  property p_stb; cycle_stb |=> (!cycle_stb) [*8]; endproperty
  a_stb: assert property (p_stb) else $error("strobe too close");
  // New targets loaded only with arm code idle
  property p_tgt_idle; $changed(target) |-> arm_code == 8'h00; endproperty
  a_tgt_idle: assert property (p_tgt_idle) else $error("target changed while armed");
  // Arm code dropped after the event
  property p_arm_back; $changed(feedback) |-> ##[1:100] arm_code == 8'h00; endproperty
  a_arm_back: assert property (p_arm_back) else $error("arm code not returned");
  c_arm: cover property (arm_code == 8'h03 && $past(arm_code) == 8'h00);
  c_fb: cover property ($changed(feedback));
  c_stb: cover property (cycle_stb);
endmodule // tos_asserts

// File: tb/timed_output_switch_scheduler_tb.sv
`timescale 1ns/1ns
module timed_output_switch_scheduler_tb;
  import tos_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, req = 1'b0;  // Bench drives
  logic [63:0] now = 64'h0, req_time = 64'h0, t_fire, t_old;  // Shared local time
  logic [3:0]  req_target = 4'h0, p;
  logic [1:0]  drive, tristate;
  logic        armed, fired, busy, done, late, late_seen;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  // Rows: delay to start time, target image
  int unsigned offs [4] = '{200, 300, 150, 250};
  logic [3:0]  tgts [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
  tos_link_if tos_link_if_inst ();
  tos_master tos_master_inst (.clk(clk), .rst(rst), .ce(1'b1), .link(tos_link_if_inst.master),
    .req(req), .req_time(req_time), .req_target(req_target), .master_time_copy(now),
    .busy(busy), .done(done), .late(late));
  tos_device tos_device_inst (.clk(clk), .rst(rst), .ce(1'b1), .link(tos_link_if_inst.device),
    .local_time(now), .drive(drive), .tristate(tristate), .armed(armed), .fired(fired));
  tos_asserts tos_asserts_inst (.clk(clk), .rst(rst), .cycle_stb(tos_link_if_inst.cycle_stb),
    .start_time(tos_link_if_inst.start_time), .target(tos_link_if_inst.target),
    .arm_code(tos_link_if_inst.arm_code), .feedback(tos_link_if_inst.feedback));
  initial forever #20 clk = ~clk;
  // Time base, fire stamp, late capture, hang guard
  always @(posedge clk) begin
    now <= now + 64'h1;
    cyc <= cyc + 1;
    if (fired === 1'b1) t_fire <= now;
    if (late === 1'b1) late_seen <= 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  // Request one event, check hold while armed, wait for done
  task automatic run(logic [63:0] t, logic [3:0] tg);
    int i;
    @(posedge clk) #1;
    req_time = t;
    req_target = tg;
    req = 1'b1;
    late_seen = 1'b0;
    p = {tristate, drive};
    for (i = 0; i < 100 && busy !== 1'b1; i++) @(posedge clk) #1;
    chk("busy", 8'h01, {7'h0, busy});
    req = 1'b0;
    for (i = 0; i < 200 && armed !== 1'b1; i++) @(posedge clk) #1;
    chk("armed", 8'h01, {7'h0, armed});
    if (t > now) chk("hold", {4'h0, p}, {4'h0, tristate, drive});
    for (i = 0; i < 2000 && done !== 1'b1; i++) @(posedge clk) #1;
    chk("done", 8'h01, {7'h0, done});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    chk("reset", 8'h00, {2'b00, armed, fired, tristate, drive});
    $display("reset test done");
    // Ordinary events, re-armed each time
    for (int r = 0; r < 4; r++) begin
      run(now + 64'(offs[r]), tgts[r]);
      chk("feedback", {4'h0, tgts[r]}, tos_link_if_inst.feedback);
      chk("outputs", {4'h0, tgts[r][3], tgts[r][1], tgts[r][2], tgts[r][0]},
          {4'h0, tristate, drive});
      chk("fire time", 8'h00, {7'h0, t_fire < req_time || t_fire > req_time + 64'h3});
      $display("row %0d test done", r);
    end
    repeat (60) @(posedge clk);
    #1 chk("arm idle", 8'h00, tos_link_if_inst.arm_code);
    // Start time already past: flagged and still applied
    run(now - 64'h10, 4'h3);
    chk("late", 8'h01, {7'h0, late_seen});
    chk("late fb", 8'h03, tos_link_if_inst.feedback);
    $display("late test done");
    // Power loss while armed discards the event
    @(posedge clk) #1;
    req_time = now + 64'h12C;
    req_target = 4'hF;
    req = 1'b1;
    for (int i = 0; i < 200 && armed !== 1'b1; i++) @(posedge clk) #1;
    chk("armed pl", 8'h01, {7'h0, armed});
    t_old = t_fire;
    req = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (400) @(posedge clk);
    #1 chk("lost arm", 8'h00, {7'h0, armed});
    chk("lost fb", 8'h00, tos_link_if_inst.feedback);
    chk("no fire", 8'h00, {7'h0, t_fire !== t_old});
    $display("power loss test done");
    final_report();
  end
endmodule // timed_output_switch_scheduler_tb
